//--- rtl/eil_pkg.sv
// package for the ethernet interrupt aggregation block
// assumes one system clock and a synchronous active-high reset
package eil_pkg;

  // cpu-side register selects
  localparam logic       SEL_ETH_EN    = 1'b0;
  localparam logic       SEL_ETH_FLAGS = 1'b1;
  // phy-side register selects
  localparam logic       SEL_PHY_EN    = 1'b0;
  localparam logic       SEL_PHY_FLAGS = 1'b1;

  // eth_irq_enable / eth_irq_flags bit positions
  localparam int         BIT_RX_PENDING  = 6;
  localparam int         BIT_COPY_DONE   = 5;
  localparam int         BIT_LINK_CHANGE = 4;
  localparam int         BIT_TX_DONE     = 3;
  localparam int         BIT_TX_FAULT    = 1;
  localparam int         BIT_RX_FAULT    = 0;
  localparam logic [7:0] ETH_EN_MASK     = 8'h7b;
  localparam logic [7:0] ETH_EN_RESET    = 8'h00;
  localparam logic [7:0] ETH_FLAG_RESET  = 8'h00;

  // phy_irq_enable / phy_irq_flags bit positions
  localparam int          BIT_PHY_LINK_EN   = 4;
  localparam int          BIT_PHY_GLOBAL_EN = 1;
  localparam int          BIT_PHY_LINK_FLAG = 4;
  localparam int          BIT_PHY_GLOB_FLAG = 2;
  localparam logic [15:0] PHY_EN_MASK       = 16'h0012;
  localparam logic [15:0] PHY_EN_RESET      = 16'h0000;

  // clearable flags handled by flag cells
  localparam int NUM_CLR_FLAGS = 4;

  // one-cycle event pulses from datapath, dma and phy
  typedef struct packed {
    logic copy_done;
    logic tx_done;
    logic tx_fault;
    logic rx_fault;
    logic link_status;
  } eil_evt_t;

  // cpu register port
  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [7:0] wdata;
  } eil_cpu_req_t;

  // phy management port
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } eil_phy_req_t;

  // main module state
  typedef struct packed {
    logic [7:0]  eth_en;
    logic        rx_pending;
    logic        link_change;
    logic        phy_link_en;
    logic        phy_glob_en;
    logic        phy_link_flag;
    logic        phy_glob_flag;
    logic        irq;
    logic [7:0]  cpu_rdata;
    logic [15:0] phy_rdata;
  } eil_state_t;

  // flag cell state
  typedef struct packed {
    logic q;
  } eil_cell_t;

endpackage

//--- rtl/eil_flag_cell.sv
// sticky flag bit: hardware set, software clear, set wins
// assumes set and clear pulses on the same clock
`timescale 1ns/1ps
module eil_flag_cell (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);
  import eil_pkg::*;

  eil_cell_t st_r;
  eil_cell_t st_nxt;

  // set beats clear in the same cycle
  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.q = 1'b0;
    end
    if (set) begin
      st_nxt.q = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

endmodule

//--- rtl/eil_irq.sv
// ethernet interrupt aggregation: enables, flags, phy enables and flags
// assumes all inputs come from logic on the same system clock
`timescale 1ns/1ps

module eil_irq (
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire eil_pkg::eil_evt_t   evt,
  input  wire logic [7:0]          pending_packet_count,
  input  wire logic                packet_count_decrement,
  input  wire logic                module_global_irq_en,
  input  wire eil_pkg::eil_cpu_req_t cpu_req,
  input  wire eil_pkg::eil_phy_req_t phy_req,
  output logic [7:0]               cpu_rdata,
  output logic [15:0]              phy_rdata,
  output logic                     master_ethernet_irq_flag
);
  import eil_pkg::*;

  eil_state_t                 st_r;
  eil_state_t                 st_nxt;
  logic [NUM_CLR_FLAGS-1:0]   cell_set;
  logic [NUM_CLR_FLAGS-1:0]   cell_clr;
  logic [NUM_CLR_FLAGS-1:0]   cell_q;
  logic [7:0]                 flags;
  logic                       phy_flag_rd;
  logic                       link_ok;
  logic                       irq_src;

  // bit position of each clearable flag cell
  function automatic int cell_bit(input int i);
    case (i)
      0:       cell_bit = BIT_COPY_DONE;
      1:       cell_bit = BIT_TX_DONE;
      2:       cell_bit = BIT_TX_FAULT;
      default: cell_bit = BIT_RX_FAULT;
    endcase
  endfunction

  // events set cells with no enable in the path
  assign cell_set = {evt.rx_fault, evt.tx_fault, evt.tx_done,
                     evt.copy_done};

  // clearable flags: writing zero to a bit clears it
  genvar g;
  generate
    for (g = 0; g < NUM_CLR_FLAGS; g++) begin : g_cell
      assign cell_clr[g] = cpu_req.wr && cpu_req.sel == SEL_ETH_FLAGS &&
                           !cpu_req.wdata[cell_bit(g)];
      eil_flag_cell u_cell (
        .clock (clock),
        .srst  (srst),
        .set   (cell_set[g]),
        .clr   (cell_clr[g]),
        .q     (cell_q[g])
      );
    end
  endgenerate

  // assembled flag byte, unimplemented bits zero
  always_comb begin
    flags                  = 8'h00;
    flags[BIT_RX_PENDING]  = st_r.rx_pending;
    flags[BIT_COPY_DONE]   = cell_q[0];
    flags[BIT_LINK_CHANGE] = st_r.link_change;
    flags[BIT_TX_DONE]     = cell_q[1];
    flags[BIT_TX_FAULT]    = cell_q[2];
    flags[BIT_RX_FAULT]    = cell_q[3];
  end

  assign phy_flag_rd = phy_req.rd && phy_req.sel == SEL_PHY_FLAGS;
  assign link_ok     = st_r.phy_link_en && st_r.phy_glob_en;
  // any enabled flag standing, before the global gate
  assign irq_src     = |(flags & st_r.eth_en);

  // next state of registers, phy flags and master flag
  always_comb begin
    st_nxt = st_r;
    if (cpu_req.wr && cpu_req.sel == SEL_ETH_EN) begin
      st_nxt.eth_en = cpu_req.wdata & ETH_EN_MASK;
    end
    if (phy_req.wr && phy_req.sel == SEL_PHY_EN) begin
      st_nxt.phy_link_en = phy_req.wdata[BIT_PHY_LINK_EN];
      st_nxt.phy_glob_en = phy_req.wdata[BIT_PHY_GLOBAL_EN];
    end
    // pending flag follows counter; drops only on decrement while the count is zero
    if (pending_packet_count != 8'h00) begin
      st_nxt.rx_pending = 1'b1;
    end else if (packet_count_decrement) begin
      st_nxt.rx_pending = 1'b0;
    end
    // phy flags cleared by a management read, event wins
    if (phy_flag_rd) begin
      st_nxt.phy_link_flag = 1'b0;
      st_nxt.phy_glob_flag = 1'b0;
      st_nxt.link_change   = 1'b0;
    end
    if (evt.link_status) begin
      st_nxt.phy_link_flag = 1'b1;
      if (link_ok) begin
        st_nxt.phy_glob_flag = 1'b1;
        st_nxt.link_change   = 1'b1;
      end
    end
    st_nxt.irq = module_global_irq_en && irq_src;
    // read data registered every cycle
    st_nxt.cpu_rdata = (cpu_req.sel == SEL_ETH_EN) ? st_r.eth_en : flags;
    st_nxt.phy_rdata = 16'h0000;
    if (phy_req.sel == SEL_PHY_EN) begin
      st_nxt.phy_rdata[BIT_PHY_LINK_EN]   = st_r.phy_link_en;
      st_nxt.phy_rdata[BIT_PHY_GLOBAL_EN] = st_r.phy_glob_en;
    end else begin
      st_nxt.phy_rdata[BIT_PHY_LINK_FLAG] = st_r.phy_link_flag;
      st_nxt.phy_rdata[BIT_PHY_GLOB_FLAG] = st_r.phy_glob_flag;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r        <= '0;
      st_r.eth_en <= ETH_EN_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cpu_rdata                = st_r.cpu_rdata;
  assign phy_rdata                = st_r.phy_rdata;
  assign master_ethernet_irq_flag = st_r.irq;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_irq_cause;
    $rose(master_ethernet_irq_flag) |->
      $past(module_global_irq_en) && $past(irq_src);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("master flag rose without enabled flag");

  property p_irq_gate;
    !module_global_irq_en |=> !master_ethernet_irq_flag;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("master flag set while global enable low");

  property p_tx_set;
    evt.tx_done |=> flags[BIT_TX_DONE];
  endproperty
  a_tx_set: assert property (p_tx_set)
    else $error("transmit flag not set by event");

  property p_fault_set;
    evt.tx_fault && evt.rx_fault |=> flags[BIT_TX_FAULT] &&
      flags[BIT_RX_FAULT];
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault flags not set by events");

  property p_copy_set;
    evt.copy_done ##1 1'b1 |-> flags[BIT_COPY_DONE];
  endproperty
  a_copy_set: assert property (p_copy_set)
    else $error("copy flag not set by event");

  property p_en_reserved;
    (cpu_rdata & ~ETH_EN_MASK) == 8'h00 && flags[7] == 1'b0 &&
      flags[2] == 1'b0;
  endproperty
  a_en_reserved: assert property (p_en_reserved)
    else $error("unimplemented bit reads nonzero");

  property p_pending;
    pending_packet_count != 8'h00 |=> flags[BIT_RX_PENDING];
  endproperty
  a_pending: assert property (p_pending)
    else $error("pending flag low with packets waiting");

  property p_pending_fall;
    $fell(st_r.rx_pending) |-> $past(packet_count_decrement) &&
      $past(pending_packet_count) == 8'h00;
  endproperty
  a_pending_fall: assert property (p_pending_fall)
    else $error("pending flag cleared without decrement");

  property p_link_gate;
    $rose(st_r.link_change) |-> $past(link_ok) && $past(evt.link_status);
  endproperty
  a_link_gate: assert property (p_link_gate)
    else $error("link flag set without both phy enables");

  property p_phy_rd_clear;
    phy_flag_rd && !evt.link_status |=> !st_r.link_change &&
      !st_r.phy_link_flag && !st_r.phy_glob_flag;
  endproperty
  a_phy_rd_clear: assert property (p_phy_rd_clear)
    else $error("phy flag read did not clear flags");

  property p_link_only_rd;
    $fell(st_r.link_change) |-> $past(phy_flag_rd);
  endproperty
  a_link_only_rd: assert property (p_link_only_rd)
    else $error("link flag cleared without phy read");

  property p_glob_gate;
    !st_r.phy_glob_en |=> !$rose(st_r.phy_glob_flag);
  endproperty
  a_glob_gate: assert property (p_glob_gate)
    else $error("phy global flag set while phy disabled");

  c_irq:  cover property (evt.rx_fault ##[1:4] master_ethernet_irq_flag);
  c_link: cover property (evt.link_status && link_ok ##1 st_r.link_change);
  c_clr:  cover property (cell_set[1] && cell_clr[1] ##1 cell_q[1]);

endmodule

//--- bench/eil_host_model.sv
// host model: latches the master ethernet request like a cpu flag bit
// assumes the block's clock and synchronous active-high reset
`timescale 1ns/1ps
module eil_host_model (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic irq,
  input  wire logic ack,
  output logic      req_r
);
  logic irq_d_r;
  // a rising request sets the latch, firmware ack clears it
  always_ff @(posedge clock) begin
    if (srst) begin
      req_r   <= 1'b0;
      irq_d_r <= 1'b0;
    end else begin
      irq_d_r <= irq;
      if (irq && !irq_d_r)
        req_r <= 1'b1;
      else if (ack)
        req_r <= 1'b0;
    end
  end
endmodule

//--- bench/eil_irq_tb_top.sv
// testbench for the ethernet interrupt aggregation block
// assumes eil_pkg and the host model are compiled first
`timescale 1ns/1ps
module eil_irq_tb_top;
  import eil_pkg::*;
  logic         clock;
  logic         srst;
  eil_evt_t     evt;
  logic [7:0]   cnt;
  logic         dec;
  logic         gen;
  eil_cpu_req_t cq;
  eil_phy_req_t pq;
  logic [7:0]   cpu_rdata;
  logic [15:0]  phy_rdata;
  logic         irq;
  logic         ack;
  logic         host_req;
  int           errors;
  int           total_checks;

  eil_irq u_dut (.clock(clock), .srst(srst), .evt(evt),
    .pending_packet_count(cnt), .packet_count_decrement(dec),
    .module_global_irq_en(gen), .cpu_req(cq), .phy_req(pq),
    .cpu_rdata(cpu_rdata), .phy_rdata(phy_rdata),
    .master_ethernet_irq_flag(irq));
  eil_host_model u_host (.clock(clock), .srst(srst), .irq(irq),
    .ack(ack), .req_r(host_req));

  // compare, count and report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic cpu_wr(input logic s, input logic [7:0] d);
    cyc(1);
    cq = '{sel: s, wr: 1'b1, wdata: d};
    cyc(1);
    cq.wr = 1'b0;
  endtask
  // read data is registered one edge after the select
  task automatic cpu_chk(input logic s, input logic [7:0] e);
    cyc(1);
    cq.sel = s;
    cyc(1);
    chk({8'h00, cpu_rdata}, {8'h00, e});
  endtask
  task automatic phy_wr(input logic [15:0] d);
    cyc(1);
    pq = '{sel: SEL_PHY_EN, wr: 1'b1, rd: 1'b0, wdata: d};
    cyc(1);
    pq.wr = 1'b0;
  endtask
  task automatic phy_chk(input logic s, input logic r, input logic [15:0] e);
    cyc(1);
    pq.sel = s;
    pq.rd = r;
    cyc(1);
    pq.rd = 1'b0;
    chk(phy_rdata, e);
  endtask
  task automatic pulse(input eil_evt_t e);
    cyc(1);
    evt = e;
    cyc(1);
    evt = '0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // cut a hang short
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    srst = 1'b1; evt = '0; cnt = 8'h00; dec = 1'b0; gen = 1'b0;
    cq = '0; pq = '0; ack = 1'b0; errors = 0; total_checks = 0;
    cyc(10);
    srst = 1'b0;
    cpu_chk(SEL_ETH_EN, 8'h00);
    cpu_chk(SEL_ETH_FLAGS, 8'h00);
    phy_chk(SEL_PHY_EN, 1'b0, 16'h0000);
    cpu_wr(SEL_ETH_EN, 8'hff);
    cpu_chk(SEL_ETH_EN, 8'h7b);
    phy_wr(16'hffff);
    phy_chk(SEL_PHY_EN, 1'b0, 16'h0012);
    // rx fault, tx fault, tx, dma with the global enable off
    for (int i = 1; i < 5; i++) pulse(eil_evt_t'(5'h01 << i));
    cpu_chk(SEL_ETH_FLAGS, 8'h2b);
    chk(irq, 1'b0);
    gen = 1'b1;
    cyc(1);
    chk(irq, 1'b1);
    cyc(1);
    chk(host_req, 1'b1);
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    chk(host_req, 1'b0);
    cpu_wr(SEL_ETH_FLAGS, 8'h00);
    cpu_chk(SEL_ETH_FLAGS, 8'h00);
    chk(irq, 1'b0);
    // stale flags cleared above before narrowing the enables
    cpu_wr(SEL_ETH_EN, 8'h02);
    pulse(5'h08);
    cyc(1);
    chk(irq, 1'b0);
    pulse(5'h04);
    cyc(1);
    chk(irq, 1'b1);
    cpu_wr(SEL_ETH_FLAGS, 8'h00);
    gen = 1'b0;
    // pending packets: set, hold, clear only on decrement at zero
    cnt = 8'h03;
    cpu_chk(SEL_ETH_FLAGS, 8'h40);
    cpu_wr(SEL_ETH_FLAGS, 8'h00);
    cpu_chk(SEL_ETH_FLAGS, 8'h40);
    dec = 1'b1;
    cyc(1);
    dec = 1'b0;
    cnt = 8'h00;
    cpu_chk(SEL_ETH_FLAGS, 8'h40);
    dec = 1'b1;
    cyc(1);
    dec = 1'b0;
    cpu_chk(SEL_ETH_FLAGS, 8'h00);
    // link change with both phy enables on, then with the phy global enable alone
    pulse(5'h01);
    cpu_wr(SEL_ETH_FLAGS, 8'h00);
    cpu_chk(SEL_ETH_FLAGS, 8'h10);
    phy_chk(SEL_PHY_FLAGS, 1'b1, 16'h0014);
    cpu_chk(SEL_ETH_FLAGS, 8'h00);
    phy_wr(16'h0002);
    pulse(5'h01);
    cpu_chk(SEL_ETH_FLAGS, 8'h00);
    phy_chk(SEL_PHY_FLAGS, 1'b1, 16'h0010);
    // link enable alone, phy global enable off: only the phy link flag reported
    phy_wr(16'h0010);
    pulse(5'h01);
    cpu_chk(SEL_ETH_FLAGS, 8'h00);
    phy_chk(SEL_PHY_FLAGS, 1'b1, 16'h0010);
    // pending packets reach the master flag once enabled
    cpu_wr(SEL_ETH_EN, 8'h40);
    gen = 1'b1;
    cnt = 8'h01;
    cyc(2);
    chk(irq, 1'b1);
    tally_and_finish();
  end
endmodule
